//--- mrs_map.vh
/*
 * constants of the modbus rtu slave frame handler: register offsets,
 * function and exception codes, reset values, value ranges and timing.
 * assumes it is included by bare name into each design file that needs it.
 */
`ifndef MRS_MAP_VH
`define MRS_MAP_VH

// register offsets
`define MRS_REG_CURRENT      8'h01
`define MRS_REG_SCALE_LOW    8'h06
`define MRS_REG_SCALE_HIGH   8'h07
`define MRS_REG_DEC_POINT    8'h08
`define MRS_REG_SLAVE_ADDR   8'h20
`define MRS_REG_IDENT        8'h21
`define MRS_REG_LINE_RATE    8'h22
`define MRS_REG_WRITE_PERMIT 8'h23

// function codes
`define MRS_FC_READ          8'h03
`define MRS_FC_WRITE_ONE     8'h06
`define MRS_FC_WRITE_MANY    8'h10
`define MRS_FC_EXC_BIT       8'h80

// exception codes
`define MRS_EXC_NONE         8'h00
`define MRS_EXC_FUNCTION     8'h01
`define MRS_EXC_ADDRESS      8'h02
`define MRS_EXC_VALUE        8'h03
`define MRS_EXC_NO_PERMIT    8'h08

// addressing and frame limits
`define MRS_BROADCAST        8'h00
`define MRS_MAX_REGS         16'h0010
`define MRS_BUF_DEPTH        64
`define MRS_BUF_LAST         7'h40
`define MRS_SHORT_LEN        7'h08
`define MRS_MANY_HDR_LEN     7'h09
`define MRS_MIN_LEN          7'h04

// reset values (4.00 ma, high scale 100.0 with one decimal) and crc constants
`define MRS_RST_CURRENT      16'h0190
`define MRS_RST_SCALE_LOW    16'h0000
`define MRS_RST_SCALE_HIGH   16'h03E8
`define MRS_RST_DEC_POINT    2'h1
`define MRS_RST_SLAVE_ADDR   8'h00
`define MRS_RST_LINE_RATE    3'h3
`define MRS_RST_PERMIT       1'b1
`define MRS_CRC_INIT         16'hFFFF
`define MRS_CRC_POLY         16'hA001

// value ranges
`define MRS_CUR_MIN          16'h0190
`define MRS_CUR_MAX          16'h07D0
`define MRS_SCALE_MIN        16'hFC19
`define MRS_SCALE_MAX        16'h270F
`define MRS_DP_MAX           16'h0003
`define MRS_ADDR_MAX         16'h00C7
`define MRS_RATE_MAX         16'h0007
`define MRS_PERMIT_MAX       16'h0001

// timing: core clock and the silent gap in half bit times (3.5 chars of 11 bits)
`define MRS_CLK_HZ           25000000
`define MRS_GAP_HALF_BITS    77

`endif

//--- mrs_crc16.v
/*
 * running crc-16 of a modbus rtu byte stream, one byte per strobe.
 * assumes strobes and clear come from logic on core_clk.
 */
`timescale 1ns/1ps
`include "mrs_map.vh"

module mrs_crc16 (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        crc_clear,
   input  wire        byte_valid,
   input  wire [7:0]  byte_in,
   output wire [15:0] crc_value
);
   reg [15:0] crc_reg;
   reg [15:0] crc_next;
   integer    i;

   // bitwise reflected update of one byte
   always @* begin
      crc_next = crc_reg ^ {8'h00, byte_in};
      for (i = 0; i < 8; i = i + 1) begin
         if (crc_next[0]) begin
            crc_next = (crc_next >> 1) ^ `MRS_CRC_POLY;
         end else begin
            crc_next = crc_next >> 1;
         end
      end
   end

   // clear wins over a strobe in the same cycle
   always @(posedge core_clk) begin
      if (reset || crc_clear) begin
         crc_reg <= `MRS_CRC_INIT;
      end else if (byte_valid) begin
         crc_reg <= crc_next;
      end
   end

   assign crc_value = crc_reg;
endmodule

//--- mrs_gap_timer.v
/*
 * silent gap detector: pulses once 3.5 character times pass after the last byte.
 * assumes restart pulses come from logic on core_clk at the byte rate.
 */
`timescale 1ns/1ps
`include "mrs_map.vh"

module mrs_gap_timer #(
   parameter CLK_HZ = `MRS_CLK_HZ
) (
   input  wire       core_clk,
   input  wire       reset,
   input  wire       restart,
   input  wire [2:0] rate_sel,
   output reg        gap_done
);
   reg [19:0] count_reg;
   reg        armed_reg;
   reg [19:0] limit;
   integer    baud;
   integer    gap_clks;

   // gap length in clocks for the selected line rate, clocks per bit rounded down, halving rounded up
   always @* begin
      case (rate_sel)
         3'h0:    baud = 1200;
         3'h1:    baud = 2400;
         3'h2:    baud = 4800;
         3'h3:    baud = 9600;
         3'h4:    baud = 19200;
         3'h5:    baud = 38400;
         3'h6:    baud = 57600;
         default: baud = 115200;
      endcase
      gap_clks = ((CLK_HZ / baud) * `MRS_GAP_HALF_BITS + 1) / 2;
      limit    = gap_clks[19:0]; // longest gap still fits 20 bits
   end

   // count down from each byte, pulse once at the end
   always @(posedge core_clk) begin
      if (reset) begin
         count_reg <= 20'h00000;
         armed_reg <= 1'b0;
         gap_done  <= 1'b0;
      end else if (restart) begin
         count_reg <= limit;
         armed_reg <= 1'b1;
         gap_done  <= 1'b0;
      end else if (armed_reg && count_reg <= 20'h00001) begin
         armed_reg <= 1'b0;
         gap_done  <= 1'b1;
      end else begin
         count_reg <= count_reg - 20'h00001;
         gap_done  <= 1'b0;
      end
   end
endmodule

//--- mrs_frame_handler.v
/*
 * modbus rtu slave frame handler of a regulated current source: collects a
 * frame, checks it, runs read/write functions on the holding registers and
 * sends the normal or exception answer byte by byte.
 * assumes a uart on core_clk delivers received bytes as one-cycle strobes and
 * takes answer bytes with a ready handshake; bit timing lives in that uart.
 */
`timescale 1ns/1ps
`include "mrs_map.vh"

module mrs_frame_handler #(
   parameter        CLK_HZ  = `MRS_CLK_HZ,
   parameter [15:0] ID_CODE = 16'h5A5A // arbitrary value
) (
   input  wire        core_clk,
   input  wire        reset,
   input  wire [7:0]  rx_data,
   input  wire        rx_valid,
   input  wire        tx_ready,
   input  wire        menu_permit_set,
   output reg  [7:0]  tx_data,
   output reg         tx_valid,
   output reg  [2:0]  line_rate_select,
   output reg  [7:0]  slave_address,
   output reg         remote_write_permit,
   output reg  [15:0] output_current_value,
   output reg  [15:0] scale_low_value,
   output reg  [15:0] scale_high_value,
   output reg  [1:0]  decimal_point_position
);
   localparam [2:0] ST_RX    = 3'h0;
   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_SCAN  = 3'h2;
   localparam [2:0] ST_APPLY = 3'h3;
   localparam [2:0] ST_SEND  = 3'h4;
   localparam [2:0] ST_DONE  = 3'h5;

   reg  [7:0]  buf_mem [0:`MRS_BUF_DEPTH-1];
   reg  [6:0]  rx_len_reg;
   reg  [2:0]  state_reg;
   reg  [7:0]  exc_reg;
   reg  [4:0]  k_reg;
   reg  [5:0]  t_reg;
   reg         crc_clear_reg;
   reg         addr_pend_reg;
   reg  [7:0]  addr_new_reg;
   wire [15:0] rx_crc;
   wire [15:0] tx_crc;
   wire        gap_done;
   wire        rx_take;
   wire        tx_load;
   wire [7:0]  func;
   wire [15:0] start_reg;
   wire [15:0] word45;
   wire [15:0] n_regs;
   wire        broadcast;
   reg  [15:0] cur_reg;
   reg  [15:0] wval;
   reg  [5:0]  widx;
   reg  [5:0]  rd_off;
   reg  [15:0] rd_addr;
   reg  [15:0] rd_val;
   reg  [6:0]  reply_len;
   reg  [7:0]  reply_byte;
   reg         reply_is_crc;

   // byte collection in the receive state only
   assign rx_take   = rx_valid && state_reg == ST_RX;
   assign func      = buf_mem[1];
   assign start_reg = {buf_mem[2], buf_mem[3]};
   assign word45    = {buf_mem[4], buf_mem[5]};
   assign n_regs    = (func == `MRS_FC_WRITE_ONE) ? 16'h0001 : word45;
   assign broadcast = buf_mem[0] == `MRS_BROADCAST;
   assign tx_load   = state_reg == ST_SEND && !tx_valid;

   mrs_crc16 u_rx_crc (
      .core_clk   (core_clk),
      .reset      (reset),
      .crc_clear  (crc_clear_reg),
      .byte_valid (rx_take),
      .byte_in    (rx_data),
      .crc_value  (rx_crc)
   );

   mrs_crc16 u_tx_crc (
      .core_clk   (core_clk),
      .reset      (reset),
      .crc_clear  (crc_clear_reg),
      .byte_valid (tx_load && !reply_is_crc),
      .byte_in    (reply_byte),
      .crc_value  (tx_crc)
   );

   mrs_gap_timer #(
      .CLK_HZ (CLK_HZ)
   ) u_gap (
      .core_clk (core_clk),
      .reset    (reset),
      .restart  (rx_take),
      .rate_sel (line_rate_select),
      .gap_done (gap_done)
   );

   // register read mux; values carry no decimal point
   function [15:0] reg_value;
      input [15:0] addr;
      begin
         case (addr)
            {8'h00, `MRS_REG_CURRENT}:      reg_value = output_current_value;
            {8'h00, `MRS_REG_SCALE_LOW}:    reg_value = scale_low_value;
            {8'h00, `MRS_REG_SCALE_HIGH}:   reg_value = scale_high_value;
            {8'h00, `MRS_REG_DEC_POINT}:    reg_value = {14'h0000, decimal_point_position};
            {8'h00, `MRS_REG_SLAVE_ADDR}:   reg_value = {8'h00, slave_address};
            {8'h00, `MRS_REG_IDENT}:        reg_value = ID_CODE;
            {8'h00, `MRS_REG_LINE_RATE}:    reg_value = {13'h0000, line_rate_select};
            {8'h00, `MRS_REG_WRITE_PERMIT}: reg_value = {15'h0000, remote_write_permit};
            default:                        reg_value = 16'h0000;
         endcase
      end
   endfunction

   // register existence; writable marks everything except the code register
   function reg_exists;
      input [15:0] addr;
      input        writing;
      begin
         case (addr)
            {8'h00, `MRS_REG_CURRENT},
            {8'h00, `MRS_REG_SCALE_LOW},
            {8'h00, `MRS_REG_SCALE_HIGH},
            {8'h00, `MRS_REG_DEC_POINT},
            {8'h00, `MRS_REG_SLAVE_ADDR},
            {8'h00, `MRS_REG_LINE_RATE},
            {8'h00, `MRS_REG_WRITE_PERMIT}: reg_exists = 1'b1;
            {8'h00, `MRS_REG_IDENT}:        reg_exists = !writing;
            default:                        reg_exists = 1'b0;
         endcase
      end
   endfunction

   // permitted value range of each writable register
   function value_ok;
      input [15:0] addr;
      input [15:0] val;
      begin
         case (addr)
            {8'h00, `MRS_REG_CURRENT}:      value_ok = val >= `MRS_CUR_MIN && val <= `MRS_CUR_MAX;
            {8'h00, `MRS_REG_SCALE_LOW},
            {8'h00, `MRS_REG_SCALE_HIGH}:   value_ok = $signed(val) >= $signed(`MRS_SCALE_MIN)
                                                    && $signed(val) <= $signed(`MRS_SCALE_MAX);
            {8'h00, `MRS_REG_DEC_POINT}:    value_ok = val <= `MRS_DP_MAX;
            {8'h00, `MRS_REG_SLAVE_ADDR}:   value_ok = val <= `MRS_ADDR_MAX;
            {8'h00, `MRS_REG_LINE_RATE}:    value_ok = val <= `MRS_RATE_MAX;
            {8'h00, `MRS_REG_WRITE_PERMIT}: value_ok = val <= `MRS_PERMIT_MAX;
            default:                        value_ok = 1'b0;
         endcase
      end
   endfunction

   // register under scan and the value a write carries for it
   always @* begin
      cur_reg = start_reg + {11'h000, k_reg};
      widx    = 6'h07 + {k_reg, 1'b0};
      if (func == `MRS_FC_WRITE_ONE) begin
         wval = word45;
      end else begin
         wval = {buf_mem[widx], buf_mem[widx + 6'h01]};
      end
   end

   // answer byte at position t_reg
   always @* begin
      rd_off       = (t_reg - 6'h03) >> 1;
      rd_addr      = start_reg + {10'h000, rd_off};
      rd_val       = reg_value(rd_addr);
      reply_is_crc = 1'b0;
      reply_len    = (exc_reg != `MRS_EXC_NONE) ? 7'h05
                   : (func == `MRS_FC_READ) ? 7'h05 + {1'b0, word45[5:0]} + {1'b0, word45[5:0]} : `MRS_SHORT_LEN;
      if (exc_reg != `MRS_EXC_NONE) begin
         case (t_reg)
            6'h00:   reply_byte = buf_mem[0];
            6'h01:   reply_byte = func | `MRS_FC_EXC_BIT;
            default: reply_byte = exc_reg;
         endcase
      end else if (func == `MRS_FC_WRITE_ONE) begin
         reply_byte = buf_mem[t_reg];
      end else if (func == `MRS_FC_READ && t_reg == 6'h02) begin
         reply_byte = {word45[6:0], 1'b0};
      end else if (func == `MRS_FC_READ && t_reg >= 6'h03) begin
         reply_byte = t_reg[0] ? rd_val[15:8] : rd_val[7:0];
      end else begin
         reply_byte = buf_mem[t_reg];
      end
      // closing crc low then high, except for the echoed single write
      if (func != `MRS_FC_WRITE_ONE || exc_reg != `MRS_EXC_NONE) begin
         if ({1'b0, t_reg} == reply_len - 7'h02) begin
            reply_byte   = tx_crc[7:0];
            reply_is_crc = 1'b1;
         end else if ({1'b0, t_reg} == reply_len - 7'h01) begin
            reply_byte   = tx_crc[15:8];
            reply_is_crc = 1'b1;
         end
      end
   end

   // frame buffer writes
   always @(posedge core_clk) begin
      if (rx_take && rx_len_reg < `MRS_BUF_LAST) begin
         buf_mem[rx_len_reg[5:0]] <= rx_data;
      end
   end

   // frame sequencer
   always @(posedge core_clk) begin
      if (reset) begin
         state_reg     <= ST_RX;
         rx_len_reg    <= 7'h00;
         exc_reg       <= `MRS_EXC_NONE;
         k_reg         <= 5'h00;
         t_reg         <= 6'h00;
         crc_clear_reg <= 1'b0;
         tx_valid      <= 1'b0;
         tx_data       <= 8'h00;
      end else begin
         crc_clear_reg <= 1'b0;
         case (state_reg)
            ST_RX: begin
               if (rx_take && rx_len_reg <= `MRS_BUF_LAST) begin
                  rx_len_reg <= rx_len_reg + 7'h01;
               end
               if (gap_done && rx_len_reg != 7'h00) begin
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               k_reg <= 5'h00;
               t_reg <= 6'h00;
               if (rx_len_reg < `MRS_MIN_LEN || rx_len_reg > `MRS_BUF_LAST || rx_crc != 16'h0000
                   || (buf_mem[0] != slave_address && !broadcast)) begin
                  state_reg <= ST_DONE;
               end else if (func != `MRS_FC_READ && func != `MRS_FC_WRITE_ONE
                            && func != `MRS_FC_WRITE_MANY) begin
                  exc_reg   <= `MRS_EXC_FUNCTION;
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end else if (rx_len_reg < `MRS_SHORT_LEN || n_regs == 16'h0000 || n_regs > `MRS_MAX_REGS
                            || (func != `MRS_FC_WRITE_MANY && rx_len_reg != `MRS_SHORT_LEN)
                            || (func == `MRS_FC_WRITE_MANY
                                && (buf_mem[6] != {word45[6:0], 1'b0}
                                    || rx_len_reg != `MRS_MANY_HDR_LEN + {word45[5:0], 1'b0}))) begin
                  exc_reg   <= `MRS_EXC_VALUE;
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end else if (func != `MRS_FC_READ && !remote_write_permit) begin
                  exc_reg   <= `MRS_EXC_NO_PERMIT;
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end else begin
                  state_reg <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               // every register checked before any is written
               if (!reg_exists(cur_reg, func != `MRS_FC_READ)) begin
                  exc_reg   <= `MRS_EXC_ADDRESS;
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end else if (func != `MRS_FC_READ && !value_ok(cur_reg, wval)) begin
                  exc_reg   <= `MRS_EXC_VALUE;
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end else if ({11'h000, k_reg} == n_regs - 16'h0001) begin
                  k_reg     <= 5'h00;
                  state_reg <= (func != `MRS_FC_READ) ? ST_APPLY : (broadcast ? ST_DONE : ST_SEND);
               end else begin
                  k_reg <= k_reg + 5'h01;
               end
            end
            ST_APPLY: begin
               if ({11'h000, k_reg} == n_regs - 16'h0001) begin
                  state_reg <= broadcast ? ST_DONE : ST_SEND;
               end
               k_reg <= k_reg + 5'h01;
            end
            ST_SEND: begin
               if (tx_load) begin
                  tx_data  <= reply_byte;
                  tx_valid <= 1'b1;
               end else if (tx_ready) begin
                  tx_valid <= 1'b0;
                  t_reg    <= t_reg + 6'h01;
                  if ({1'b0, t_reg} == reply_len - 7'h01) begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            default: begin
               rx_len_reg    <= 7'h00;
               exc_reg       <= `MRS_EXC_NONE;
               crc_clear_reg <= 1'b1;
               state_reg     <= ST_RX;
            end
         endcase
      end
   end

   // holding registers; defaults as after power-on
   always @(posedge core_clk) begin
      if (reset) begin
         output_current_value   <= `MRS_RST_CURRENT;
         scale_low_value        <= `MRS_RST_SCALE_LOW;
         scale_high_value       <= `MRS_RST_SCALE_HIGH;
         decimal_point_position <= `MRS_RST_DEC_POINT;
         slave_address          <= `MRS_RST_SLAVE_ADDR;
         line_rate_select       <= `MRS_RST_LINE_RATE;
         remote_write_permit    <= `MRS_RST_PERMIT;
         addr_pend_reg          <= 1'b0;
         addr_new_reg           <= 8'h00;
      end else begin
         if (state_reg == ST_APPLY) begin
            case (cur_reg)
               {8'h00, `MRS_REG_CURRENT}:    output_current_value   <= wval;
               {8'h00, `MRS_REG_SCALE_LOW}:  scale_low_value        <= wval;
               {8'h00, `MRS_REG_SCALE_HIGH}: scale_high_value       <= wval;
               {8'h00, `MRS_REG_DEC_POINT}:  decimal_point_position <= wval[1:0];
               {8'h00, `MRS_REG_SLAVE_ADDR}: begin
                  addr_pend_reg <= 1'b1;
                  addr_new_reg  <= wval[7:0];
               end
               {8'h00, `MRS_REG_LINE_RATE}:  line_rate_select <= wval[2:0];
               default: ;
            endcase
         end
         // a local enable wins; a remote write can only clear
         if (menu_permit_set) begin
            remote_write_permit <= 1'b1;
         end else if (state_reg == ST_APPLY && cur_reg == {8'h00, `MRS_REG_WRITE_PERMIT}) begin
            remote_write_permit <= remote_write_permit & wval[0];
         end
         // new address takes over once the answer has gone out
         if (state_reg == ST_DONE && addr_pend_reg) begin
            slave_address <= addr_new_reg;
            addr_pend_reg <= 1'b0;
         end
      end
   end
endmodule

//--- mrs_frame_handler_props.sv
/* checker of the frame handler ports: answer handshake, defaults, permit flag.
   assumes a bind onto mrs_frame_handler, one clock, synchronous reset. */
`timescale 1ns/1ps
module mrs_frame_handler_props (
   input logic        core_clk,
   input logic        reset,
   input logic [7:0]  rx_data,
   input logic        rx_valid,
   input logic        tx_ready,
   input logic        menu_permit_set,
   input logic [7:0]  tx_data,
   input logic        tx_valid,
   input logic [2:0]  line_rate_select,
   input logic [7:0]  slave_address,
   input logic        remote_write_permit,
   input logic [15:0] output_current_value,
   input logic [15:0] scale_low_value,
   input logic [15:0] scale_high_value,
   input logic [1:0]  decimal_point_position
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // byte offered but not taken, and byte taken
   sequence s_wait; tx_valid && !tx_ready; endsequence
   sequence s_take; tx_valid && tx_ready; endsequence
   chk_tx_hold: assert property (s_wait |=> tx_valid && $stable(tx_data))
      else $error("answer byte changed before taken");
   chk_tx_release: assert property (s_take |=> !tx_valid)
      else $error("answer byte not released after take");
   chk_rst_comm: assert property (disable iff (1'b0) reset |=> !tx_valid && line_rate_select == 3'h3
      && slave_address == 8'h00 && remote_write_permit) else $error("bad link defaults");
   chk_rst_output: assert property (disable iff (1'b0) reset |=> output_current_value == 16'h0190
      && scale_high_value == 16'h03E8 && scale_low_value == 16'h0000 && decimal_point_position == 2'h1)
      else $error("bad output defaults");
   chk_permit_menu: assert property (menu_permit_set |=> remote_write_permit)
      else $error("menu did not restore permit");
   chk_permit_rise: assert property ($rose(remote_write_permit) |-> $past(menu_permit_set) || $past(reset))
      else $error("permit set without menu");
   chk_rate_idle: assert property ($changed(line_rate_select) && !$past(reset) |-> !$past(tx_valid))
      else $error("line rate changed inside an answer");
   chk_addr_idle: assert property ($changed(slave_address) && !$past(reset) |-> !tx_valid)
      else $error("address changed inside an answer");
   chk_current_range: assert property (output_current_value >= 16'h0190 && output_current_value <= 16'h07D0)
      else $error("current out of range");
endmodule
bind mrs_frame_handler mrs_frame_handler_props u_mrs_frame_handler_props (.core_clk, .reset, .rx_data, .rx_valid,
   .tx_ready, .menu_permit_set, .tx_data, .tx_valid, .line_rate_select, .slave_address, .remote_write_permit,
   .output_current_value, .scale_low_value, .scale_high_value, .decimal_point_position);

//--- mrs_master_model.sv
/* modbus rtu master model: sends one request, collects the answer bytes.
   assumes the bench drives nothing else on rx and tx handshake lines. */
`timescale 1ns/1ps
module mrs_master_model (
   input  logic       core_clk,
   input  logic [7:0] tx_data,
   input  logic       tx_valid,
   output logic [7:0] rx_data,
   output logic       rx_valid,
   output logic       tx_ready
);
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // one byte step of the modbus crc
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      int i;
      c = c ^ {8'h00, b};
      for (i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      return c;
   endfunction
   // request bytes then crc low, high; bad flips one crc bit
   task automatic xfer(input logic [87:0] q, input logic [3:0] n, input logic bad, output logic [7:0] r [$]);
      logic [15:0] c;
      int k;
      r = {};
      c = 16'hFFFF;
      for (k = 0; k < n + 2; k++) begin
         @(negedge core_clk);
         if (k < n) rx_data = q[8*(n-1-k) +: 8];
         else rx_data = (k == n) ? c[7:0] ^ {7'h00, bad} : c[15:8];
         if (k < n) c = crc_step(c, rx_data);
         rx_valid = 1'b1;
      end
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      // silent line, ready alternates slow and prompt
      for (k = 0; k < 1500; k++) begin
         @(negedge core_clk);
         tx_ready = k[1];
         @(posedge core_clk);
         if (tx_valid === 1'b1 && tx_ready) r.push_back(tx_data);
      end
   endtask
endmodule

//--- test_mrs_frame_handler.sv
/* self-checking bench of the frame handler: table of request and answer frames.
   assumes mrs_master_model as the link partner and a short gap through CLK_HZ. */
`timescale 1ns/1ps
module test_mrs_frame_handler;
   typedef struct packed {
      logic [87:0] q;
      logic [3:0]  qn;
      logic [71:0] a;
      logic [3:0]  an;
      logic        bad;
   } mrs_row_t;
   logic        core_clk, reset, menu_permit_set, rx_valid, tx_ready, tx_valid, remote_write_permit;
   logic [7:0]  rx_data, tx_data, slave_address;
   logic [2:0]  line_rate_select;
   logic [1:0]  decimal_point_position;
   logic [15:0] output_current_value, scale_low_value, scale_high_value, c;
   logic [7:0]  exp [$];
   logic [7:0]  got [$];
   mrs_row_t    rows [19];
   int          mismatches, compares, i, k;
   mrs_frame_handler #(.CLK_HZ(100000)) u_mrs_frame_handler (.core_clk(core_clk), .reset(reset),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready), .menu_permit_set(menu_permit_set),
      .tx_data(tx_data), .tx_valid(tx_valid), .line_rate_select(line_rate_select), .slave_address(slave_address),
      .remote_write_permit(remote_write_permit), .output_current_value(output_current_value),
      .scale_low_value(scale_low_value), .scale_high_value(scale_high_value),
      .decimal_point_position(decimal_point_position));
   mrs_master_model u_mrs_master_model (.core_clk(core_clk), .tx_data(tx_data), .tx_valid(tx_valid),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_defaults;
      check("link", {1'h0, 3'h3, 8'h00, 1'h1, 2'h1, 16'h0000}, {tx_valid, line_rate_select, slave_address,
         remote_write_permit, decimal_point_position, scale_low_value});
      check("output", 32'h019003E8, {output_current_value, scale_high_value});
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      wrap_up;
   end
   initial begin
      rows = '{'{88'h000600200001, 4'h6, 72'h0, 4'h0, 1'h0},
         '{88'h010300210001, 4'h6, 72'h0103025A5A, 4'h5, 1'h0},
         '{88'h010400010001, 4'h6, 72'h018401, 4'h3, 1'h0},
         '{88'h010300050001, 4'h6, 72'h018302, 4'h3, 1'h0},
         '{88'h010600010064, 4'h6, 72'h018603, 4'h3, 1'h0},
         '{88'h010300010011, 4'h6, 72'h018303, 4'h3, 1'h0},
         '{88'h010300060003, 4'h6, 72'h010306000003E80001, 4'h9, 1'h0},
         '{88'h0106000101C2, 4'h6, 72'h0106000101C2, 4'h6, 1'h0},
         '{88'h01100006000204000A0014, 4'hB, 72'h011000060002, 4'h6, 1'h0},
         '{88'h010600210001, 4'h6, 72'h018602, 4'h3, 1'h0},
         '{88'h030300210001, 4'h6, 72'h0, 4'h0, 1'h0},
         '{88'h010300210001, 4'h6, 72'h0, 4'h0, 1'h1},
         '{88'h010600200002, 4'h6, 72'h010600200002, 4'h6, 1'h0},
         '{88'h020300010001, 4'h6, 72'h02030201C2, 4'h5, 1'h0},
         '{88'h020600220004, 4'h6, 72'h020600220004, 4'h6, 1'h0},
         '{88'h020600230000, 4'h6, 72'h020600230000, 4'h6, 1'h0},
         '{88'h020600230001, 4'h6, 72'h028608, 4'h3, 1'h0},
         '{88'h020300220002, 4'h6, 72'h02030400040000, 4'h7, 1'h0},
         '{88'h02100006000103000A, 4'h9, 72'h029003, 4'h3, 1'h0}};
      reset = 1'b1;
      menu_permit_set = 1'b0;
      repeat (16) @(negedge core_clk);
      reset = 1'b0;
      check_defaults;
      // table rows: expected answer plus its own crc
      for (i = 0; i < 19; i++) begin
         u_mrs_master_model.xfer(rows[i].q, rows[i].qn, rows[i].bad, got);
         exp = {};
         c = 16'hFFFF;
         for (k = 0; k < rows[i].an; k++) begin
            exp.push_back(rows[i].a[8*(rows[i].an-1-k) +: 8]);
            c = u_mrs_master_model.crc_step(c, exp[k]);
         end
         if (rows[i].an != 4'h0) exp.push_back(c[7:0]);
         if (rows[i].an != 4'h0) exp.push_back(c[15:8]);
         check("length", exp.size(), got.size());
         for (k = 0; k < exp.size() && k < got.size(); k++) check("byte", exp[k], got[k]);
         $display("test %0d done", i);
      end
      check("rate", 3'h4, line_rate_select);
      check("permit", 1'h0, remote_write_permit);
      @(negedge core_clk);
      menu_permit_set = 1'b1;
      @(negedge core_clk);
      menu_permit_set = 1'b0;
      check("permit", 1'h1, remote_write_permit);
      $display("test permit done");
      // second reset in mid-run
      reset = 1'b1;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      check_defaults;
      $display("test reset done");
      wrap_up;
   end
endmodule
